// ==== otpc_consts.svh ====
// Timing counts, pin widths and limits for the OTP EPROM programmer controller
`ifndef OTPC_CONSTS_SVH
`define OTPC_CONSTS_SVH
`define OTPC_CLK_MHZ 100
`define OTPC_ADDR_W 17
`define OTPC_DATA_W 8
`define OTPC_ERASED_BYTE 8'hFF
// Times in ns as printed, cycles derived (least rounds up, longest down)
`define OTPC_SETUP_NS 2000
`define OTPC_SETUP_CYC ((`OTPC_SETUP_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_PULSE_MIN_NS 30000
`define OTPC_PULSE_MAX_NS 105000
`define OTPC_PULSE_CYC ((`OTPC_PULSE_MIN_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_PULSE_MAX_CYC ((`OTPC_PULSE_MAX_NS * `OTPC_CLK_MHZ) / 1000)
`define OTPC_VERIFY_NS 150
`define OTPC_VERIFY_CYC ((`OTPC_VERIFY_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_READ_NS 70
`define OTPC_READ_CYC ((`OTPC_READ_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_MAX_PULSES 25
`define OTPC_ID_BYTE_A0 0
`define OTPC_ID_BANK_A1 1
`define OTPC_ID_HV_A9 9
`endif

// ==== otpc_pkg.sv ====
// Types shared by the OTP EPROM programmer controller
package otpc_pkg;
	// Control pins as driven to the device, all active low except supplies
	typedef struct packed {
		logic chipSelN;
		logic outGateN;
		logic programStrobeN;
		logic vppRaised;
		logic idModeHighVoltage;
	} otpc_pins_s;

	typedef enum logic [1:0] {
		OTPC_CMD_READ = 2'h0,
		OTPC_CMD_PROGRAM = 2'h1,
		OTPC_CMD_IDENT = 2'h2,
		OTPC_CMD_CHECK = 2'h3
	} otpc_cmd_e;

	typedef enum logic [9:0] {
		OTPC_IDLE = 10'h001,
		OTPC_SETUP = 10'h002,
		OTPC_PULSE = 10'h004,
		OTPC_GAP = 10'h008,
		OTPC_VERIFY = 10'h010,
		OTPC_COMPARE = 10'h020,
		OTPC_READ = 10'h040,
		OTPC_FETCH = 10'h080,
		OTPC_DONE = 10'h100,
		OTPC_FAIL = 10'h200
	} otpc_state_e;
endpackage

// ==== otpc_data_mem.sv ====
// Small source buffer holding the bytes to be written to the device
`timescale 1ns/1ps
`default_nettype none
module otpc_data_mem #(
	parameter int DATA_W = 8,
	parameter int DEPTH_W = 4
) (
	input wire logic clk,
	input wire logic wrEn,
	input wire logic [DEPTH_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [DEPTH_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] memArray [0:(1<<DEPTH_W)-1];

	// Registered read keeps the programmer's data path free of ram delay
	always_ff @(posedge clk)
	begin
		if (wrEn)
			memArray[wrAddr] <= wrData;
		rdData <= memArray[rdAddr];
	end
endmodule
`default_nettype wire

// ==== otpc_programmer.sv ====
// Host-side programmer and reader for a 128K x 8 one-time-programmable EPROM
`timescale 1ns/1ps
`default_nettype none
`include "otpc_consts.svh"
module otpc_programmer #(
	parameter int ADDR_W = `OTPC_ADDR_W,
	parameter int BUF_W = 4,
	parameter int MAX_PULSES = `OTPC_MAX_PULSES,
	parameter int PULSE_CYC = `OTPC_PULSE_CYC,
	parameter int SETUP_CYC = `OTPC_SETUP_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire otpc_pkg::otpc_cmd_e cmdOp,
	input wire logic [ADDR_W-1:0] cmdAddr,
	input wire logic [BUF_W-1:0] cmdCount,
	input wire logic idBank,
	input wire logic idByte,
	input wire logic bufWrEn,
	input wire logic [BUF_W-1:0] bufWrAddr,
	input wire logic [7:0] bufWrData,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe,
	output logic [ADDR_W-1:0] addressLines,
	output otpc_pkg::otpc_pins_s pins,
	output logic busy,
	output logic doneValid,
	output logic doneFail,
	output logic [7:0] rdByte,
	output logic rdParityOk
);
	// ------------------------------------------------------------
	// Types, pin synchroniser and source buffer
	// ------------------------------------------------------------
	otpc_pkg::otpc_state_e state_ff, nxt_state;
	otpc_pkg::otpc_cmd_e op_ff, nxt_op;
	otpc_pkg::otpc_pins_s pins_ff, nxt_pins;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [BUF_W-1:0] idx_ff, nxt_idx, last_ff, nxt_last;
	logic [16:0] tmr_ff, nxt_tmr;
	logic [7:0] pulses_ff, nxt_pulses;
	logic [7:0] dOut_ff, nxt_dOut;
	logic dOe_ff, nxt_dOe;
	logic busy_ff, nxt_busy, done_ff, nxt_done, fail_ff, nxt_fail;
	logic [7:0] rdByte_ff, nxt_rdByte;
	logic parOk_ff, nxt_parOk;
	logic [7:0] dataMeta_ff, dataSync_ff;
	logic [7:0] srcByte;

	// Data pins come from off chip, so two flops before any use
	always_ff @(posedge clk)
	begin
		dataMeta_ff <= dataIn;
		dataSync_ff <= dataMeta_ff;
	end

	otpc_data_mem #(.DATA_W(8), .DEPTH_W(BUF_W)) uSrc (
		.clk(clk),
		.wrEn(bufWrEn),
		.wrAddr(bufWrAddr),
		.wrData(bufWrData),
		.rdAddr(nxt_idx),
		.rdData(srcByte)
	);

	// Odd parity check of an identifier byte, top bit as parity
	function automatic logic oddParity(input logic [7:0] b);
		oddParity = ^b;
	endfunction

	// Pin set for a mode; select, gate and strobe are given asserted (1 = pin low)
	function automatic otpc_pkg::otpc_pins_s modePins(input logic sel, input logic gate,
		input logic strobe, input logic vpp, input logic hv);
		modePins = '{chipSelN: ~sel, outGateN: ~gate, programStrobeN: ~strobe,
			vppRaised: vpp, idModeHighVoltage: hv};
	endfunction

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Standby (select high) is the resting state, keeping the part floating
	always_comb
	begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_pins = pins_ff;
		nxt_addr = addr_ff;
		nxt_idx = idx_ff;
		nxt_last = last_ff;
		nxt_tmr = tmr_ff;
		nxt_pulses = pulses_ff;
		nxt_dOut = dOut_ff;
		nxt_dOe = dOe_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_fail = fail_ff;
		nxt_rdByte = rdByte_ff;
		nxt_parOk = parOk_ff;
		case (state_ff)
			otpc_pkg::OTPC_IDLE:
			begin
				nxt_pins = modePins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
				nxt_dOe = 1'b0;
				if (cmdValid)
				begin
					nxt_op = cmdOp;
					nxt_busy = 1'b1;
					nxt_fail = 1'b0;
					nxt_idx = '0;
					nxt_last = cmdCount;
					nxt_pulses = '0;
					nxt_addr = cmdAddr;
					nxt_tmr = 17'(SETUP_CYC);
					if (cmdOp == otpc_pkg::OTPC_CMD_PROGRAM)
					begin
						// Supply raised, gate high, strobe low, select still high
						nxt_pins = modePins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
						nxt_state = otpc_pkg::OTPC_SETUP;
					end
					else if (cmdOp == otpc_pkg::OTPC_CMD_IDENT)
					begin
						// Other lines high, bank and byte on lines one and zero
						// Offered so the user can pick the algorithm before writing
						nxt_addr = '1;
						nxt_addr[`OTPC_ID_BANK_A1] = idBank;
						nxt_addr[`OTPC_ID_BYTE_A0] = idByte;
						nxt_pins = modePins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
						nxt_tmr = 17'(SETUP_CYC);
						nxt_state = otpc_pkg::OTPC_READ;
					end
					else
					begin
						nxt_pins = modePins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
						nxt_tmr = 17'(`OTPC_READ_CYC);
						nxt_state = otpc_pkg::OTPC_READ;
					end
				end
			end
			otpc_pkg::OTPC_SETUP:
			begin
				// Full byte driven on all data lines before the pulse
				nxt_dOut = srcByte;
				nxt_dOe = 1'b1;
				if (tmr_ff == 17'h0)
				begin
					// Only the select carries the pulse, so parallel parts share the rest
					nxt_pins.chipSelN = 1'b0;
					nxt_tmr = 17'(PULSE_CYC);
					nxt_pulses = pulses_ff + 8'h01;
					nxt_state = otpc_pkg::OTPC_PULSE;
				end
				else
					nxt_tmr = tmr_ff - 17'h1;
			end
			otpc_pkg::OTPC_PULSE:
			begin
				// Shortest legal pulse, repeated only while verify fails
				if (tmr_ff == 17'h0)
				begin
					nxt_pins.chipSelN = 1'b1;
					nxt_tmr = 17'(SETUP_CYC);
					nxt_state = otpc_pkg::OTPC_GAP;
				end
				else
					nxt_tmr = tmr_ff - 17'h1;
			end
			otpc_pkg::OTPC_GAP:
			begin
				if (tmr_ff == 17'h0)
				begin
					nxt_dOe = 1'b0;
					nxt_pins = modePins(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
					nxt_tmr = 17'(`OTPC_VERIFY_CYC + 2);
					nxt_state = otpc_pkg::OTPC_VERIFY;
				end
				else
					nxt_tmr = tmr_ff - 17'h1;
			end
			otpc_pkg::OTPC_VERIFY:
			begin
				// Extra two cycles cover the input synchroniser
				if (tmr_ff == 17'h0)
					nxt_state = otpc_pkg::OTPC_COMPARE;
				else
					nxt_tmr = tmr_ff - 17'h1;
			end
			otpc_pkg::OTPC_COMPARE:
			begin
				nxt_rdByte = dataSync_ff;
				nxt_pins = modePins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
				nxt_tmr = 17'(SETUP_CYC);
				if (dataSync_ff == dOut_ff)
				begin
					nxt_pulses = '0;
					if (idx_ff == last_ff)
					begin
						// Final pass rereads everything at normal supply
						nxt_op = otpc_pkg::OTPC_CMD_CHECK;
						nxt_idx = '0;
						nxt_addr = addr_ff - ADDR_W'(last_ff);
						nxt_pins = modePins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
						nxt_tmr = 17'(`OTPC_READ_CYC);
						nxt_state = otpc_pkg::OTPC_READ;
					end
					else
					begin
						nxt_idx = idx_ff + 1'b1;
						nxt_addr = addr_ff + 1'b1;
						nxt_state = otpc_pkg::OTPC_SETUP;
					end
				end
				else if (pulses_ff >= 8'(MAX_PULSES))
				begin
					nxt_fail = 1'b1;
					nxt_state = otpc_pkg::OTPC_DONE;
				end
				else
					nxt_state = otpc_pkg::OTPC_SETUP;
			end
			otpc_pkg::OTPC_READ:
			begin
				// Gate low with select low; wait access plus two sync flops
				if (tmr_ff == 17'h0)
				begin
					nxt_tmr = 17'h2;
					nxt_state = otpc_pkg::OTPC_FETCH;
				end
				else
					nxt_tmr = tmr_ff - 17'h1;
			end
			otpc_pkg::OTPC_FETCH:
			begin
				if (tmr_ff != 17'h0)
					nxt_tmr = tmr_ff - 17'h1;
				else
				begin
					nxt_rdByte = dataSync_ff;
					nxt_parOk = oddParity(dataSync_ff);
					if (op_ff == otpc_pkg::OTPC_CMD_CHECK)
					begin
						if (dataSync_ff != srcByte)
							nxt_fail = 1'b1;
						if (idx_ff == last_ff)
							nxt_state = otpc_pkg::OTPC_DONE;
						else
						begin
							nxt_idx = idx_ff + 1'b1;
							nxt_addr = addr_ff + 1'b1;
							nxt_tmr = 17'(`OTPC_READ_CYC);
							nxt_state = otpc_pkg::OTPC_READ;
						end
					end
					else
						nxt_state = otpc_pkg::OTPC_DONE;
				end
			end
			otpc_pkg::OTPC_DONE:
			begin
				nxt_pins = modePins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
				nxt_dOe = 1'b0;
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				nxt_state = otpc_pkg::OTPC_IDLE;
			end
			default:
				nxt_state = otpc_pkg::OTPC_IDLE;
		endcase
	end

	// Register every piece of sequencer state; reset goes to standby
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_ff <= otpc_pkg::OTPC_IDLE;
			op_ff <= otpc_pkg::OTPC_CMD_READ;
			pins_ff <= '{chipSelN: 1'b1, outGateN: 1'b1, programStrobeN: 1'b1,
				vppRaised: 1'b0, idModeHighVoltage: 1'b0};
			addr_ff <= '0;
			idx_ff <= '0;
			last_ff <= '0;
			tmr_ff <= '0;
			pulses_ff <= '0;
			dOut_ff <= `OTPC_ERASED_BYTE;
			dOe_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
			rdByte_ff <= '0;
			parOk_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			pins_ff <= nxt_pins;
			addr_ff <= nxt_addr;
			idx_ff <= nxt_idx;
			last_ff <= nxt_last;
			tmr_ff <= nxt_tmr;
			pulses_ff <= nxt_pulses;
			dOut_ff <= nxt_dOut;
			dOe_ff <= nxt_dOe;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			fail_ff <= nxt_fail;
			rdByte_ff <= nxt_rdByte;
			parOk_ff <= nxt_parOk;
		end
	end

	// Outputs straight from flops
	assign pins = pins_ff;
	assign addressLines = addr_ff;
	assign dataOut = dOut_ff;
	assign dataOe = dOe_ff;
	assign busy = busy_ff;
	assign doneValid = done_ff;
	assign doneFail = fail_ff;
	assign rdByte = rdByte_ff;
	assign rdParityOk = parOk_ff;
endmodule
`default_nettype wire

// ==== otpc_programmer_sva.sv ====
// Port-level checker for the OTP EPROM programmer controller
`timescale 1ns/1ps
`default_nettype none
module otpc_programmer_sva #(
	parameter int ADDR_W = 17,
	parameter int PULSE_CYC = 3000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire logic busy,
	input wire logic doneValid,
	input wire logic dataOe,
	input wire logic idBank,
	input wire logic idByte,
	input wire logic [ADDR_W-1:0] addressLines,
	input wire otpc_pkg::otpc_pins_s pins
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [15:0] pulseLen_ff;
	// Length of the current program pulse; a stuck counter would hide short pulses
	always_ff @(posedge clk)
	begin
		if (!rstn || pins.chipSelN || pins.programStrobeN)
			pulseLen_ff <= 16'h0000;
		else
			pulseLen_ff <= pulseLen_ff + 16'h0001;
	end
	busy_take_a: assert property (!busy && cmdValid |=> busy)
		else $error("command not taken");
	prog_mode_a: assert property (!pins.programStrobeN && !pins.chipSelN |->
		pins.vppRaised && pins.outGateN) else $error("pulse outside program mode");
	pulse_width_a: assert property ($rose(pins.chipSelN) && !$past(pins.programStrobeN) |->
		pulseLen_ff >= PULSE_CYC && pulseLen_ff <= 16'h2904) else $error("bad pulse width");
	byte_drive_a: assert property (!pins.programStrobeN && !pins.chipSelN |-> dataOe)
		else $error("byte not driven during pulse");
	verify_pins_a: assert property (pins.vppRaised && !pins.outGateN && !pins.chipSelN |->
		pins.programStrobeN) else $error("verify with strobe low");
	no_clash_a: assert property (!pins.chipSelN && !pins.outGateN |-> !dataOe)
		else $error("host drives while device outputs");
	id_lines_a: assert property (pins.idModeHighVoltage |-> &addressLines[ADDR_W-1:10] &&
		&addressLines[8:2] && !pins.vppRaised) else $error("bad lines in identify");
	id_select_a: assert property (pins.idModeHighVoltage && !pins.outGateN |->
		addressLines[1:0] == {idBank, idByte}) else $error("bad identify select");
	done_pulse_a: assert property (doneValid |-> !busy ##1 !doneValid)
		else $error("done not a single pulse");
	done_standby_a: assert property (doneValid |-> pins.chipSelN && !pins.vppRaised &&
		!pins.idModeHighVoltage) else $error("not standby at done");
endmodule
bind otpc_programmer otpc_programmer_sva #(.ADDR_W(ADDR_W), .PULSE_CYC(PULSE_CYC)) i_sva (
	.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .busy(busy), .doneValid(doneValid),
	.dataOe(dataOe), .idBank(idBank), .idByte(idByte), .addressLines(addressLines), .pins(pins));
`default_nettype wire

// ==== otpc_eprom_model.sv ====
// Behavioural model of the EPROM on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module otpc_eprom_model #(
	parameter logic [7:0] MAKER_ID = 8'h2A, // Arbitrary value, odd parity
	parameter logic [7:0] TYPE_ID = 8'h83, // Arbitrary value, odd parity
	parameter logic [7:0] CONT_ID = 8'h0B // Arbitrary value, odd parity
) (
	input wire otpc_pkg::otpc_pins_s pins,
	input wire logic [16:0] addressLines,
	input wire logic [7:0] dataOut,
	input wire logic needTwo,
	output logic [7:0] dataIn
);
	logic [7:0] mem [0:63];
	logic [7:0] q;
	logic [7:0] lastQ = 8'h00;
	logic skip = 1'b1;
	logic armed = 1'b0;
	wire logic drive = !pins.chipSelN && !pins.outGateN;
	// Fresh array is all ones
	initial
	begin
		for (int i = 0; i < 64; i++)
			mem[i] = 8'hFF;
	end
	// Select-gated pulse clears bits; a slow cell ignores every other pulse
	// A pulse counts only if program mode held while select was low, so a
	// verify-to-inhibit swap at one edge writes nothing
	always @(pins.chipSelN)
	begin
		if (!pins.chipSelN)
			armed = pins.vppRaised && !pins.programStrobeN && pins.outGateN;
		else
		begin
			if (armed && pins.vppRaised && !pins.programStrobeN && pins.outGateN)
			begin
				if (!(needTwo && skip))
					mem[addressLines[5:0]] = mem[addressLines[5:0]] & dataOut;
				skip = !skip;
			end
			armed = 1'b0;
		end
	end
	// Identify replaces array data; bank low gives the continuation code
	always_comb
		q = !pins.idModeHighVoltage ? mem[addressLines[5:0]] :
			!addressLines[1] ? CONT_ID : addressLines[0] ? TYPE_ID : MAKER_ID;
	// Floating bus shows the inverse of the last value, not a kind leftover
	always @*
		if (drive)
			lastQ = q;
	assign #30 dataIn = drive ? q : ~lastQ;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the OTP EPROM programmer controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] MK = 8'h2A;
	localparam logic [7:0] TY = 8'h83;
	localparam logic [7:0] CT = 8'h0B;
	localparam int MAXP = 3;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cmdValid = 1'b0;
	otpc_pkg::otpc_cmd_e cmdOp = otpc_pkg::OTPC_CMD_READ;
	logic [16:0] cmdAddr = '0;
	logic [3:0] cmdCount = '0;
	logic idBank = 1'b0;
	logic idByte = 1'b0;
	logic bufWrEn = 1'b0;
	logic [3:0] bufWrAddr = '0;
	logic [7:0] bufWrData = '0;
	logic [7:0] dataIn, dataOut, rdByte;
	logic dataOe, busy, doneValid, doneFail, rdParityOk;
	logic [16:0] addressLines;
	otpc_pkg::otpc_pins_s pins;
	logic needTwo = 1'b1;
	logic [31:0] seed = 32'h6d3ba847;
	logic [7:0] img [0:3];
	logic [16:0] base;
	logic [7:0] keep;
	int bad_count = 0;
	int n_checks = 0;
	int pulses = 0;
	otpc_programmer #(.MAX_PULSES(MAXP), .PULSE_CYC(5), .SETUP_CYC(3)) i_dut (.clk(clk),
		.rstn(rstn), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdCount(cmdCount),
		.idBank(idBank), .idByte(idByte), .bufWrEn(bufWrEn), .bufWrAddr(bufWrAddr),
		.bufWrData(bufWrData), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.addressLines(addressLines), .pins(pins), .busy(busy), .doneValid(doneValid),
		.doneFail(doneFail), .rdByte(rdByte), .rdParityOk(rdParityOk));
	otpc_eprom_model #(.MAKER_ID(MK), .TYPE_ID(TY), .CONT_ID(CT)) i_mem (.pins(pins),
		.addressLines(addressLines), .dataOut(dataOut), .needTwo(needTwo), .dataIn(dataIn));
	initial
		forever #5 clk = ~clk;
	// Count program pulses at the select fall; the gap-to-verify swap also drops select but with strobe high, so it is not counted
	always @(negedge pins.chipSelN)
		if (pins.vppRaised && !pins.programStrobeN)
			pulses++;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] id_exp(input logic [1:0] k);
		return k[1] ? (k[0] ? TY : MK) : CT;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// One command; done is awaited under a bound
	task automatic run(input otpc_pkg::otpc_cmd_e op, input logic [16:0] a, input logic [3:0] n,
		input logic [1:0] k);
		int i;
		@(posedge clk);
		cmdOp <= op;
		cmdAddr <= a;
		cmdCount <= n;
		{idBank, idByte} <= k;
		cmdValid <= 1'b1;
		@(posedge clk);
		cmdValid <= 1'b0;
		for (i = 0; i < 5000; i++)
		begin
			@(posedge clk);
			#1;
			if (doneValid === 1'b1)
				break;
		end
		if (i == 5000)
		begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task automatic fill(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			bufWrEn <= 1'b1;
			bufWrAddr <= i[3:0];
			bufWrData <= img[i];
		end
		@(posedge clk);
		bufWrEn <= 1'b0;
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			run(otpc_pkg::OTPC_CMD_READ, {13'h0003, seed[3:0]}, 4'h0, 2'h0);
			chk8("blank byte", 8'hFF, rdByte);
			chk8("blank parity", 8'h00, {7'h00, rdParityOk});
		end
		$display("test blank read done");
		for (int k = 0; k < 4; k++)
		begin
			run(otpc_pkg::OTPC_CMD_IDENT, 17'h00000, 4'h0, k[1:0]);
			chk8("id byte", id_exp(k[1:0]), rdByte);
			chk8("id parity", 8'h01, {7'h00, rdParityOk});
		end
		$display("test identify done");
		seed = xs(seed);
		base = {13'h0000, seed[3:0]};
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			img[i] = seed[7:0] & 8'hFE;
		end
		fill(4);
		pulses = 0;
		run(otpc_pkg::OTPC_CMD_PROGRAM, base, 4'h3, 2'h0);
		chk8("program fail", 8'h00, {7'h00, doneFail});
		chk8("pulse count", 8'h08, pulses[7:0]);
		for (int i = 0; i < 4; i++)
		begin
			run(otpc_pkg::OTPC_CMD_READ, base + i, 4'h0, 2'h0);
			chk8("programmed byte", img[i], rdByte);
		end
		run(otpc_pkg::OTPC_CMD_CHECK, base, 4'h3, 2'h0);
		chk8("check fail", 8'h00, {7'h00, doneFail});
		$display("test program done");
		keep = img[1];
		img[1] = 8'hFF;
		fill(2);
		pulses = 0;
		run(otpc_pkg::OTPC_CMD_PROGRAM, base, 4'h1, 2'h0);
		chk8("abort fail", 8'h01, {7'h00, doneFail});
		// Byte 0 already holds its data and verifies after one pulse
		chk8("abort pulses", 8'(MAXP + 1), pulses[7:0]);
		run(otpc_pkg::OTPC_CMD_READ, base + 1, 4'h0, 2'h0);
		chk8("unchanged byte", keep, rdByte);
		$display("test abort done");
		report_and_stop();
	end
endmodule
`default_nettype wire
